//--- bbcj_defines.svh
`ifndef BBCJ_DEFINES_SVH
`define BBCJ_DEFINES_SVH

// Program counter and return stack geometry
`define PC_W 12
`define STACK_DEPTH 6
`define SP_W 3

// Opcode fields
`define SHORT_OP_W 3
`define BR_NZ 3'h0
`define BR_NC 3'h2
`define BR_Z 3'h4
`define BR_C 3'h6
`define NIB_CALL 4'h1
`define NIB_JUMP 4'h9
`define NIB_BIT_BRANCH 4'h3
`define NIB_BIT_OP 4'hb
`define SENSE_BIT 4

// Control opcodes
`define OP_NOP 8'h2d
`define OP_SUB_RETURN 8'hcd
`define OP_INT_RETURN 8'h4d
`define OP_STOP 8'h6d
`define OP_WAIT 8'hed

// Cycle counts per group
`define CYC_SHORT 3'h2
`define CYC_CTRL 3'h2
`define CYC_BIT_OP 3'h4
`define CYC_LONG 3'h4
`define CYC_BIT_BRANCH 3'h5
`define CNT_FIRST 3'h1
`define CNT_DATA 3'h2

// Byte lengths and displacement bases
`define LEN_1 12'h001
`define LEN_2 12'h002
`define LEN_3 12'h003
`define SHORT_BASE 12'h001
`define BIT_BRANCH_BASE 12'h002

`endif

//--- bbcj_pkg.sv
`include "bbcj_defines.svh"

package bbcj_pkg;

  typedef logic [`PC_W-1:0] pc_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'h1,
    S_EXEC = 2'h2
  } state_e;

  typedef enum logic [3:0] {
    K_BR_CARRY,
    K_BR_ZERO,
    K_BR_BIT,
    K_BIT_OP,
    K_NOP,
    K_SUB_RETURN,
    K_INT_RETURN,
    K_STOP,
    K_WAIT,
    K_CALL,
    K_JUMP,
    K_ILLEGAL
  } kind_e;

  typedef struct packed {
    state_e state;
    kind_e kind;
    logic busy;
    logic [2:0] cnt;
    logic [2:0] last;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    pc_t pc;
    logic bitval;
    pc_t pc_out;
    logic pc_load;
    logic zero;
    logic carry;
    logic flags_load;
    logic [7:0] mem_addr;
    logic mem_rd_req;
    logic mem_wr_req;
    logic [7:0] mem_wr_data;
    logic done;
    logic wait_req;
    logic stop_req;
    logic push;
    logic pop;
    pc_t push_data;
  } exec_s;

  typedef struct packed {
    logic [`STACK_DEPTH-1:0][`PC_W-1:0] slots;
    logic [`SP_W-1:0] sp;
    pc_t top;
  } stack_s;

endpackage : bbcj_pkg

//--- branch_bit_control_jump_exec.sv
`timescale 1ns/1ps
`include "bbcj_defines.svh"

// Summary of operation
// - Short displacement reaches -15 to +16
// - Bit branch displacement reaches -126 to +129
// - Tested bit goes to carry, zero kept
// - Three opcode bits pick the bit
// - Bit set: two bytes, four cycles
// - Bit clear: two bytes, four cycles
// - Any bit of any data byte
// - No-operation: one byte, two cycles
// - Return reloads saved address, flags kept
// - Interrupt return also restores both flags
// - Idle instruction requests wait state
// - Halt instruction: one byte, two cycles
// - Watchdog selected turns halt into wait
// - Call: 12-bit target, four cycles
// - Jump: 12-bit target, four cycles
// - Long targets cover whole program space
module branch_bit_control_jump_exec (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Instruction in
  input wire logic instr_valid,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand1,
  input wire logic [7:0] operand2,
  input wire bbcj_pkg::pc_t pc_in,
  // Flags in
  input wire logic zero_in,
  input wire logic carry_in,
  input wire logic saved_zero,
  input wire logic saved_carry,
  // Options
  input wire logic watchdog_sel,
  // Data space
  input wire logic [7:0] mem_rd_data,
  output logic [7:0] mem_addr,
  output logic mem_rd_req,
  output logic mem_wr_req,
  output logic [7:0] mem_wr_data,
  // Results
  output logic busy,
  output logic done,
  output bbcj_pkg::pc_t pc_out,
  output logic pc_load,
  output logic zero_out,
  output logic carry_out,
  output logic flags_load,
  // Low power requests
  output logic wait_req,
  output logic stop_req
);
  import bbcj_pkg::*;

  exec_s cur;
  exec_s nxt;
  stack_if stk ();

  function automatic kind_e decode_kind(input logic [7:0] op);
    decode_kind = K_ILLEGAL;
    if (op == `OP_NOP)
      decode_kind = K_NOP;
    else if (op == `OP_SUB_RETURN)
      decode_kind = K_SUB_RETURN;
    else if (op == `OP_INT_RETURN)
      decode_kind = K_INT_RETURN;
    else if (op == `OP_STOP)
      decode_kind = K_STOP;
    else if (op == `OP_WAIT)
      decode_kind = K_WAIT;
    else if (op[`SHORT_OP_W-1:0] == `BR_C || op[`SHORT_OP_W-1:0] == `BR_NC)
      decode_kind = K_BR_CARRY;
    else if (op[`SHORT_OP_W-1:0] == `BR_Z || op[`SHORT_OP_W-1:0] == `BR_NZ)
      decode_kind = K_BR_ZERO;
    else if (op[3:0] == `NIB_CALL)
      decode_kind = K_CALL;
    else if (op[3:0] == `NIB_JUMP)
      decode_kind = K_JUMP;
    else if (op[3:0] == `NIB_BIT_BRANCH)
      decode_kind = K_BR_BIT;
    else if (op[3:0] == `NIB_BIT_OP)
      decode_kind = K_BIT_OP;
  endfunction : decode_kind

  function automatic logic [2:0] cycles_of(input kind_e k);
    case (k)
      K_BR_CARRY, K_BR_ZERO: cycles_of = `CYC_SHORT;
      K_BR_BIT: cycles_of = `CYC_BIT_BRANCH;
      K_BIT_OP: cycles_of = `CYC_BIT_OP;
      K_CALL, K_JUMP: cycles_of = `CYC_LONG;
      default: cycles_of = `CYC_CTRL;
    endcase
  endfunction : cycles_of

  // Bit number sits reversed in the top three opcode bits
  function automatic logic [2:0] bit_sel(input logic [7:0] op);
    bit_sel = {op[5], op[6], op[7]};
  endfunction : bit_sel

  function automatic pc_t short_target(input pc_t pc, input logic [7:0] op);
    short_target = pc + `SHORT_BASE + {{(`PC_W - 5){op[7]}}, op[7:3]};
  endfunction : short_target

  function automatic pc_t bit_target(input pc_t pc, input logic [7:0] disp);
    bit_target = pc + `BIT_BRANCH_BASE + {{(`PC_W - 8){disp[7]}}, disp};
  endfunction : bit_target

  // Condition sense: opcode bit 2 set tests the flag for set, bit 2 clear tests it for clear
  function automatic logic short_taken(input logic [7:0] op, input logic z, input logic c);
    case (op[`SHORT_OP_W-1:0])
      `BR_C: short_taken = c;
      `BR_NC: short_taken = !c;
      `BR_Z: short_taken = z;
      default: short_taken = !z;
    endcase
  endfunction : short_taken

  always_comb
  begin
    nxt = cur;
    nxt.pc_load = 1'b0;
    nxt.flags_load = 1'b0;
    nxt.mem_rd_req = 1'b0;
    nxt.mem_wr_req = 1'b0;
    nxt.done = 1'b0;
    nxt.wait_req = 1'b0;
    nxt.stop_req = 1'b0;
    nxt.push = 1'b0;
    nxt.pop = 1'b0;
    case (cur.state)
      S_IDLE:
      begin
        if (instr_valid)
        begin
          nxt.state = S_EXEC;
          nxt.busy = 1'b1;
          nxt.kind = decode_kind(opcode);
          nxt.cnt = `CNT_FIRST;
          nxt.last = cycles_of(decode_kind(opcode));
          nxt.opcode = opcode;
          nxt.op1 = operand1;
          nxt.op2 = operand2;
          nxt.pc = pc_in;
          // Full 8-bit address reaches every data-space byte
          if (decode_kind(opcode) == K_BR_BIT || decode_kind(opcode) == K_BIT_OP)
          begin
            nxt.mem_addr = operand1;
            nxt.mem_rd_req = 1'b1;
          end
        end
      end
      S_EXEC:
      begin
        nxt.cnt = cur.cnt + 1'b1;
        // Read data arrive one cycle after the request
        if (cur.cnt == `CNT_DATA && (cur.kind == K_BR_BIT || cur.kind == K_BIT_OP))
        begin
          nxt.bitval = mem_rd_data[bit_sel(cur.opcode)];
          if (cur.kind == K_BIT_OP)
          begin
            nxt.mem_wr_req = 1'b1;
            nxt.mem_wr_data = mem_rd_data;
            nxt.mem_wr_data[bit_sel(cur.opcode)] = cur.opcode[`SENSE_BIT];
          end
        end
        if (cur.cnt == cur.last - 1'b1)
        begin
          nxt.state = S_IDLE;
          nxt.busy = 1'b0;
          nxt.done = 1'b1;
          nxt.pc_load = 1'b1;
          nxt.zero = zero_in;
          nxt.carry = carry_in;
          nxt.pc_out = cur.pc + `LEN_1;
          case (cur.kind)
            K_BR_CARRY, K_BR_ZERO:
            begin
              if (short_taken(cur.opcode, zero_in, carry_in))
                nxt.pc_out = short_target(cur.pc, cur.opcode);
            end
            K_BR_BIT:
            begin
              nxt.flags_load = 1'b1;
              nxt.carry = cur.bitval;
              nxt.pc_out = cur.pc + `LEN_3;
              if (cur.bitval == cur.opcode[`SENSE_BIT])
                nxt.pc_out = bit_target(cur.pc, cur.op2);
            end
            K_BIT_OP:
              nxt.pc_out = cur.pc + `LEN_2;
            K_CALL:
            begin
              nxt.push = 1'b1;
              nxt.push_data = cur.pc + `LEN_2;
              nxt.pc_out = {cur.opcode[7:4], cur.op1};
            end
            K_JUMP:
              nxt.pc_out = {cur.opcode[7:4], cur.op1};
            K_SUB_RETURN:
            begin
              nxt.pop = 1'b1;
              nxt.pc_out = stk.top;
            end
            K_INT_RETURN:
            begin
              nxt.pop = 1'b1;
              nxt.pc_out = stk.top;
              nxt.flags_load = 1'b1;
              nxt.zero = saved_zero;
              nxt.carry = saved_carry;
            end
            K_STOP:
            begin
              nxt.wait_req = watchdog_sel;
              nxt.stop_req = !watchdog_sel;
            end
            K_WAIT:
              nxt.wait_req = 1'b1;
            default:
              nxt.pc_out = cur.pc + `LEN_1;
          endcase
        end
      end
      default:
        nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      cur <= '0;
      cur.state <= S_IDLE;
      cur.kind <= K_NOP;
    end
    else
      cur <= nxt;
  end

  assign stk.push = cur.push;
  assign stk.pop = cur.pop;
  assign stk.wr_data = cur.push_data;

  ret_stack u_ret_stack (
    .mclk(mclk),
    .reset_n(reset_n),
    .port(stk.mem)
  );

  assign mem_addr = cur.mem_addr;
  assign mem_rd_req = cur.mem_rd_req;
  assign mem_wr_req = cur.mem_wr_req;
  assign mem_wr_data = cur.mem_wr_data;
  assign busy = cur.busy;
  assign done = cur.done;
  assign pc_out = cur.pc_out;
  assign pc_load = cur.pc_load;
  assign zero_out = cur.zero;
  assign carry_out = cur.carry;
  assign flags_load = cur.flags_load;
  assign wait_req = cur.wait_req;
  assign stop_req = cur.stop_req;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic accept;
  assign accept = !cur.busy && instr_valid;

  a_carry_branch_len: assert property (
    accept && decode_kind(opcode) == K_BR_CARRY |-> ##1 !done ##1 done && !flags_load)
    else $error("carry branch did not finish in two cycles");

  a_zero_branch_target: assert property (
    accept && decode_kind(opcode) == K_BR_ZERO && short_taken(opcode, 1'b0, 1'b0) && !zero_in
    ##1 !zero_in |-> ##1 done && pc_out == short_target($past(pc_in, 2), $past(opcode, 2)))
    else $error("taken zero branch target wrong");

  a_bit_branch_len: assert property (
    accept && decode_kind(opcode) == K_BR_BIT |-> ##1 (!done)[*4] ##1 done)
    else $error("bit branch did not take five cycles");

  a_bit_to_carry: assert property (
    done && cur.kind == K_BR_BIT |-> flags_load && carry_out == cur.bitval && zero_out == $past(zero_in))
    else $error("tested bit not copied into carry");

  a_bit_set_write: assert property (
    mem_wr_req && cur.kind == K_BIT_OP && cur.opcode[`SENSE_BIT] |-> mem_wr_data[bit_sel(cur.opcode)]
    && mem_addr == cur.op1 ##1 done)
    else $error("bit set wrote wrong value or timing");

  a_bit_clr_write: assert property (
    mem_wr_req && cur.kind == K_BIT_OP && !cur.opcode[`SENSE_BIT] |-> !mem_wr_data[bit_sel(cur.opcode)])
    else $error("bit clear left the bit set");

  a_return_flags_kept: assert property (
    done && cur.kind == K_SUB_RETURN |-> !flags_load && $past(cur.pop) == 1'b0 && $past(stk.top) == pc_out)
    else $error("return did not reload saved address");

  a_stop_to_wait: assert property (
    done && cur.kind == K_STOP && $past(watchdog_sel) |-> wait_req && !stop_req)
    else $error("halt not replaced by wait under watchdog");

  a_call_push: assert property (
    accept && decode_kind(opcode) == K_CALL |-> ##4 done && cur.push && cur.push_data == $past(pc_in, 4) + `LEN_2
    ##1 stk.top == $past(cur.push_data))
    else $error("call did not push return address");

  a_nop_len: assert property (
    accept && decode_kind(opcode) == K_NOP |-> ##1 !done ##1 done && !flags_load && pc_out == $past(pc_in, 2) + `LEN_1)
    else $error("no-operation did not finish in two cycles");

  a_int_return_flags: assert property (
    done && cur.kind == K_INT_RETURN |-> flags_load && zero_out == $past(saved_zero)
    && carry_out == $past(saved_carry) && pc_out == $past(stk.top))
    else $error("interrupt return did not restore flags");

  a_wait_req: assert property (
    accept && decode_kind(opcode) == K_WAIT |-> ##1 !done ##1 done && wait_req && !stop_req && !flags_load)
    else $error("idle instruction did not request wait");

  a_jump_target: assert property (
    accept && decode_kind(opcode) == K_JUMP |-> ##4 done && !flags_load && !cur.push
    && pc_out == {$past(opcode[7:4], 4), $past(operand1, 4)})
    else $error("jump target wrong");

  c_bit_branch_taken: cover property (done && cur.kind == K_BR_BIT && cur.bitval == cur.opcode[`SENSE_BIT]);
  c_stop_as_wait: cover property (done && cur.kind == K_STOP && wait_req);
  c_call_then_return: cover property (done && cur.kind == K_CALL ##[1:20] done && cur.kind == K_SUB_RETURN);
  c_int_return_flags: cover property (done && cur.kind == K_INT_RETURN && flags_load);

endmodule : branch_bit_control_jump_exec

//--- ret_stack.sv
`timescale 1ns/1ps
`include "bbcj_defines.svh"

// Circular return stack; overflow silently drops the oldest entry
module ret_stack (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Push and pop port
  stack_if.mem port
);
  import bbcj_pkg::*;

  stack_s cur;
  stack_s nxt;

  function automatic logic [`SP_W-1:0] sp_dec(input logic [`SP_W-1:0] sp);
    sp_dec = (sp == '0) ? `SP_W'(`STACK_DEPTH - 1) : sp - 1'b1;
  endfunction : sp_dec

  always_comb
  begin
    nxt = cur;
    if (port.push)
    begin
      nxt.slots[cur.sp] = port.wr_data;
      nxt.sp = (cur.sp == `SP_W'(`STACK_DEPTH - 1)) ? '0 : cur.sp + 1'b1;
      nxt.top = port.wr_data;
    end
    else if (port.pop)
    begin
      nxt.sp = sp_dec(cur.sp);
      nxt.top = cur.slots[sp_dec(sp_dec(cur.sp))];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cur <= '0;
    else
      cur <= nxt;
  end

  assign port.top = cur.top;

endmodule : ret_stack

//--- stack_if.sv
`timescale 1ns/1ps

interface stack_if;
  import bbcj_pkg::*;
  logic push;
  logic pop;
  pc_t wr_data;
  pc_t top;

  modport ctrl (output push, output pop, output wr_data, input top);
  modport mem (input push, input pop, input wr_data, output top);
endinterface : stack_if

//--- tb.sv
`timescale 1ns/1ps

module tb;
  import bbcj_pkg::*;

  typedef struct packed {
    logic [2:0] n;
    pc_t pc;
    logic fl;
    logic z;
    logic c;
    logic wt;
    logic st;
    logic rd;
    logic wr;
    logic [7:0] wd;
  } exp_s;

  logic mclk, reset_n, instr_valid, zero_in, carry_in, saved_zero, saved_carry, watchdog_sel;
  logic [7:0] opcode, operand1, operand2, mem_rd_data, mem_addr, mem_wr_data;
  pc_t pc_in, pc_out;
  logic mem_rd_req, mem_wr_req, busy, done, pc_load, zero_out, carry_out, flags_load, wait_req, stop_req;
  logic [7:0] mem [256];
  logic rd_hold;
  pc_t stk [$];
  int miscompares, samples_checked;
  logic [35:0] corners [] = '{36'h800000100, 36'h7e0000100, 36'h020000100, 36'h040000100,
    36'h060000100, 36'h031080100, 36'hf3ff7f100, 36'h1b0000010, 36'hebff00020, 36'hf1ff00ffe,
    36'h010000200, 36'hcd0000000, 36'h4d0000000, 36'hf9ff00000, 36'h090000fff, 36'h2d0000000,
    36'h6d0000000, 36'h6d0000000, 36'hed0000000, 36'h050000000};

  branch_bit_control_jump_exec i_dut (.mclk, .reset_n, .instr_valid, .opcode, .operand1, .operand2,
    .pc_in, .zero_in, .carry_in, .saved_zero, .saved_carry, .watchdog_sel, .mem_rd_data, .mem_addr,
    .mem_rd_req, .mem_wr_req, .mem_wr_data, .busy, .done, .pc_out, .pc_load, .zero_out, .carry_out,
    .flags_load, .wait_req, .stop_req);

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Read data is held through the sampling cycle, then scrambled so stale data cannot pass
  always @(negedge mclk)
  begin
    if (mem_wr_req === 1'b1)
      mem[mem_addr] <= mem_wr_data;
    if (mem_rd_req === 1'b1)
    begin
      mem_rd_data <= mem[mem_addr];
      rd_hold <= 1'b1;
    end
    else if (rd_hold)
      rd_hold <= 1'b0;
    else
      mem_rd_data <= ~mem_rd_data;
  end

  task automatic check(logic [15:0] seen, logic [15:0] exp, string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  function automatic exp_s predict(logic [7:0] op, o1, o2, pc_t pc, logic z, c, logic [7:0] b, pc_t top);
    exp_s r;
    logic [2:0] bn;
    logic tk;
    r = '0;
    r.n = 3'h2;
    r.pc = pc + 12'h001;
    r.z = z;
    r.c = c;
    bn = {op[5], op[6], op[7]};
    tk = op[2] ? (op[1] ? c : z) : (op[1] ? !c : !z);
    case (op)
      8'h2d: r.n = 3'h2;
      8'hcd: r.pc = top;
      8'h4d: r = '{3'h2, top, 1'b1, saved_zero, saved_carry, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00};
      8'h6d: {r.wt, r.st} = watchdog_sel ? 2'h2 : 2'h1;
      8'hed: r.wt = 1'b1;
      default:
        if (!op[0])
          r.pc = tk ? pc + 12'h001 + {{7{op[7]}}, op[7:3]} : pc + 12'h001;
        else if (op[2:0] == 3'h1)
        begin
          r.n = 3'h4;
          r.pc = {op[7:4], o1};
        end
        else if (op[3:0] == 4'h3)
        begin
          {r.n, r.rd, r.fl, r.c} = {3'h5, 1'b1, 1'b1, b[bn]};
          r.pc = (b[bn] == op[4]) ? pc + 12'h002 + {{4{o2[7]}}, o2} : pc + 12'h003;
        end
        else if (op[3:0] == 4'hb)
        begin
          {r.n, r.rd, r.wr, r.pc} = {3'h4, 1'b1, 1'b1, pc + 12'h002};
          r.wd = op[4] ? b | (8'h01 << bn) : b & ~(8'h01 << bn);
        end
    endcase
    return r;
  endfunction : predict

  task automatic run_instr(logic [7:0] op, logic [7:0] o1, logic [7:0] o2, pc_t pc);
    exp_s ex;
    int n;
    int rds;
    int wrs;
    if ((op == 8'hcd || op == 8'h4d) && stk.size() == 0)
      op = 8'h2d;
    if (op[3:0] == 4'h1 && stk.size() == 6)
      op[3] = 1'b1;
    {zero_in, carry_in, saved_zero, saved_carry} = 4'($urandom);
    watchdog_sel = ~watchdog_sel;
    {instr_valid, opcode, operand1, operand2, pc_in} = {1'b1, op, o1, o2, pc};
    ex = predict(op, o1, o2, pc, zero_in, carry_in, mem[o1], stk.size() > 0 ? stk[$] : 12'h000);
    if (op == 8'hcd || op == 8'h4d)
      void'(stk.pop_back());
    else if (op[3:0] == 4'h1)
      stk.push_back(pc + 12'h002);
    rds = 0;
    wrs = 0;
    for (n = 1; n <= 8; n++)
    begin
      @(negedge mclk);
      if (n == 1)
        check(busy, 1, "busy after accept");
      if (mem_rd_req === 1'b1)
      begin
        rds++;
        check(mem_addr, o1, "read address");
      end
      if (mem_wr_req === 1'b1)
      begin
        wrs++;
        check(mem_wr_data, ex.wd, "written byte");
      end
      if (done === 1'b1)
        break;
      // Junk while busy must be ignored
      {opcode, operand1, pc_in} = 28'($urandom);
    end
    if (n > 8)
    begin
      miscompares++;
      report_and_stop();
    end
    check(16'(n), 16'(ex.n), "cycle count");
    check({busy, pc_load}, 2'h1, "done outputs");
    check(pc_out, ex.pc, "next pc");
    check(flags_load, ex.fl, "flag load");
    if (ex.fl)
      check({zero_out, carry_out}, {ex.z, ex.c}, "flags");
    check({wait_req, stop_req}, {ex.wt, ex.st}, "low power");
    check({8'(rds), 8'(wrs)}, {7'h00, ex.rd, 7'h00, ex.wr}, "data space");
  endtask : run_instr

  initial
  begin
    miscompares = 0;
    samples_checked = 0;
    {reset_n, instr_valid, opcode, operand1, operand2, pc_in} = '0;
    {zero_in, carry_in, saved_zero, saved_carry, watchdog_sel, rd_hold} = '0;
    mem_rd_data = 8'h00;
    void'($urandom(24));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (20) @(negedge mclk);
    check({busy, done, pc_load, flags_load, wait_req, stop_req, mem_rd_req, mem_wr_req, mem_addr}, 0, "reset");
    check(pc_out, 0, "reset pc");
    reset_n = 1'b1;
    @(negedge mclk);
    foreach (corners[i])
      run_instr(corners[i][35:28], corners[i][27:20], corners[i][19:12], corners[i][11:0]);
    repeat (400)
      run_instr(8'($urandom), 8'($urandom), 8'($urandom), 12'($urandom));
    instr_valid = 1'b0;
    repeat (3) @(negedge mclk);
    report_and_stop();
  end
endmodule : tb
